// ---- include/vcc_params.svh ----
// Constants for the voltage comparator control block.
`ifndef VCC_PARAMS_SVH
`define VCC_PARAMS_SVH
`define VCC_OFS_ANALOG_ENABLE_REG    12'h000
`define VCC_OFS_CMPCTL   12'h004
`define VCC_OFS_STATUS   12'h008
`define VCC_OFS_IRQCTL   12'h00c
`define VCC_OFS_ISTAT    12'h010
`define VCC_OFS_IMASK    12'h014
`define VCC_BIT_COMPARATOR_ENABLE_BIT    7
`define VCC_BIT_RESULT   7
`define VCC_BIT_PINDRV   6
`define VCC_BIT_CHFLAG   0
`define VCC_BIT_IRQEN    0
`define VCC_BIT_GIE      1
`define VCC_VS_LSB       0
`define VCC_PS_LSB       4
`define VCC_FIELD_W      4
`define VCC_PS_LAST      4'h3
`define VCC_VS_P2P       4'h0
`define VCC_RST_BYTE     8'h00
`define VCC_RST_WORD     32'h0000_0000
`define VCC_HTRANS_NSEQ  2'b10
`define VCC_HSIZE_WORD   3'b010
`define VCC_BYTE_LSB     0
`define VCC_BYTE_W       8
`define VCC_IRQCTL_LSB   1
`define VCC_EV_LSB       0
`define VCC_EV_W         2
`define VCC_CTL_RST      2'b00
`define VCC_ISTAT_RST    2'b00
`define VCC_ADDR_RST     12'h000
`define VCC_READY        1'b1
`define VCC_RESP_OKAY    1'b0
`endif

// ---- include/vcc_pkg.sv ----
// Types shared by the voltage comparator control block.
package vcc_pkg;
   typedef enum logic {
      VCC_PAD_TO_PAD,
      VCC_PAD_TO_REF
   } vcc_mode_t;

   // Analog switch controls toward the comparator macro.
   typedef struct packed {
      logic       comp_on;
      logic       ref_to_inv;
      logic [3:0] ref_level;
      logic [3:0] noninv_pad;
      logic [3:0] inv_pad;
   } vcc_analog_t;
endpackage

// ---- hw/vcc_top.sv ----
// Voltage comparator control with AHB-Lite register slave.
// What this block does
// - Comparator off after reset; runs when enabled.
// - Halt state forces the comparator off.
// - Level field zero selects pad-to-pad mode.
// - Reference level is code sixteenths of supply.
// - Reference reaches only the inverting input.
// - Pad-to-reference: codes 0-3 pick pad A0-A3.
// - Pad-to-pad: fixed pin pairs, codes 0-3.
// - Level in bits 3:0, pad in 7:4.
// - Result differing from registered copy sets flag.
// - Status read refreshes the registered copy.
// - Result readable at status bit 7.
// - Drive bit 6 puts result on pin B3.
// - Drive bit overrides the first PWM channel.
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`include "vcc_params.svh"

module vcc_top
   import vcc_pkg::*;
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Core and analog side.
   input  wire logic        halt_state,
   input  wire logic        comp_raw,
   input  wire logic        pwm_channel_one,
   output vcc_analog_t      analog_ctl,
   output logic             pin_b3_out,
   output logic             pin_b3_oe,
   output logic             cmp_irq,
   output logic             irq
);
   logic        [7:0]  analog_enable_reg;
   logic        [7:0]  compare_control_reg;
   logic               compare_pin_drive_reg;
   logic        [1:0]  irq_ctl_reg;
   logic               compare_change_flag_reg;
   logic               held_result_reg;
   logic               res_s1_reg;
   logic               res_s2_reg;
   logic        [1:0]  istat_reg;
   logic        [1:0]  imask_reg;
   logic               wr_pend_reg;
   logic        [11:0] wr_addr_reg;
   logic        [31:0] hrdata_reg;
   vcc_analog_t        analog_reg;
   logic               pin_out_reg;
   logic               pin_oe_reg;
   logic               cmp_irq_reg;
   logic               irq_reg;
   logic               hreadyout_reg;
   logic               hresp_reg;

   // Address phase decode; hsize is not decoded since every register is a word.
   wire        take      = hsel & hready & (htrans == `VCC_HTRANS_NSEQ);
   wire        rd_take   = take & ~hwrite;
   wire        wr_take   = take & hwrite;
   wire        rd_status = rd_take & (haddr == `VCC_OFS_STATUS);
   wire        rd_istat  = rd_take & (haddr == `VCC_OFS_ISTAT);
   wire        w_analog_enable_reg   = wr_pend_reg & (wr_addr_reg == `VCC_OFS_ANALOG_ENABLE_REG);
   wire        w_cmpctl  = wr_pend_reg & (wr_addr_reg == `VCC_OFS_CMPCTL);
   wire        w_status  = wr_pend_reg & (wr_addr_reg == `VCC_OFS_STATUS);
   wire        w_irqctl  = wr_pend_reg & (wr_addr_reg == `VCC_OFS_IRQCTL);
   wire        w_imask   = wr_pend_reg & (wr_addr_reg == `VCC_OFS_IMASK);

   // Write data fields, applied at the end of the data phase.
   wire [7:0]  wr_byte   = hwdata[`VCC_BYTE_LSB +: `VCC_BYTE_W];
   wire [1:0]  wr_irqctl = hwdata[`VCC_IRQCTL_LSB +: `VCC_EV_W];
   wire [1:0]  wr_mask   = hwdata[`VCC_EV_LSB +: `VCC_EV_W];

   // Register fields.
   wire [3:0]  ref_level_select = compare_control_reg[`VCC_VS_LSB +: `VCC_FIELD_W];
   wire [3:0]  input_pad_select = compare_control_reg[`VCC_PS_LSB +: `VCC_FIELD_W];
   wire        comparator_enable_bit = analog_enable_reg[`VCC_BIT_COMPARATOR_ENABLE_BIT];
   // Halt opens every switch at once, whatever the enable bit holds.
   wire        comp_on   = comparator_enable_bit & ~halt_state;
   vcc_mode_t  mode;
   assign mode = (ref_level_select == `VCC_VS_P2P) ? VCC_PAD_TO_PAD
                                                   : VCC_PAD_TO_REF;
   wire        pad_ok    = input_pad_select <= `VCC_PS_LAST;

   // Pad codes are one-hot over pins A0 to A3; codes above 3 leave every pad switch open.
   wire [3:0]  pad_hot   = pad_ok ? (4'h1 << input_pad_select[1:0]) : 4'h0;
   wire [3:0]  pad_pair  = pad_ok ? (4'h1 << {input_pad_select[1],
                                              ~input_pad_select[0]}) : 4'h0;
   vcc_analog_t analog_next;
   always_comb begin
      analog_next.comp_on    = comp_on;
      analog_next.ref_level  = ref_level_select;
      analog_next.ref_to_inv = comp_on & (mode == VCC_PAD_TO_REF);
      analog_next.noninv_pad = comp_on ? pad_hot : 4'h0;
      analog_next.inv_pad    = (comp_on & (mode == VCC_PAD_TO_PAD)) ? pad_pair : 4'h0;
   end

   // A disabled comparator reads as low; the raw pin is synchronised first.
   wire        result    = res_s2_reg & comp_on;
   wire        mismatch  = result ^ held_result_reg;
   wire        flag_clr  = w_irqctl & ~hwdata[`VCC_BIT_CHFLAG];
   // A change in the same cycle as a software clear keeps the flag set.
   wire        flag_next = mismatch | (compare_change_flag_reg & ~flag_clr);
   wire        irq_req   = compare_change_flag_reg & irq_ctl_reg[`VCC_BIT_IRQEN]
                           & irq_ctl_reg[`VCC_BIT_GIE];
   wire [1:0]  ev        = {irq_req, mismatch};
   // Each sticky status bit obeys the same rule: an event in the cycle of the
   // clearing read keeps the bit set, so no event is ever lost.
   wire [1:0]  istat_next;
   genvar      gi;
   generate
      for (gi = 0; gi < `VCC_EV_W; gi = gi + 1) begin : g_istat
         assign istat_next[gi] = ev[gi] | (istat_reg[gi] & ~rd_istat);
      end
   endgenerate

   // Bit 7 is the live result and ignores writes; bit 6 is the pin drive.
   wire [31:0] status_word = {24'h000000, result, compare_pin_drive_reg, 6'h00};
   // Unmapped offsets read as zero and their writes are dropped.
   logic [31:0] rd_mux;
   always_comb begin
      case (haddr)
         `VCC_OFS_ANALOG_ENABLE_REG:  rd_mux = {24'h000000, analog_enable_reg};
         `VCC_OFS_CMPCTL: rd_mux = {24'h000000, compare_control_reg};
         `VCC_OFS_STATUS: rd_mux = status_word;
         `VCC_OFS_IRQCTL: rd_mux = {29'h0, irq_ctl_reg, compare_change_flag_reg};
         `VCC_OFS_ISTAT:  rd_mux = {30'h0, istat_reg};
         `VCC_OFS_IMASK:  rd_mux = {30'h0, imask_reg};
         default:         rd_mux = `VCC_RST_WORD;
      endcase
   end

   // Pin B3 carries the result when the drive bit is set and the PWM channel otherwise.
   wire        pin_next  = compare_pin_drive_reg ? result : pwm_channel_one;

   // Two flops bring the asynchronous comparator output into the clock domain.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         res_s1_reg <= 1'b0;
         res_s2_reg <= 1'b0;
      end else begin
         res_s1_reg <= comp_raw;
         res_s2_reg <= res_s1_reg;
      end
   end

   // One short process per register keeps every write strobe easy to trace.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         analog_enable_reg <= `VCC_RST_BYTE;
      end else if (w_analog_enable_reg) begin
         analog_enable_reg <= wr_byte;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         compare_control_reg <= `VCC_RST_BYTE;
      end else if (w_cmpctl) begin
         compare_control_reg <= wr_byte;
      end
   end

   // Only the drive bit of the status word is writable; the result bit is not.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         compare_pin_drive_reg <= 1'b0;
      end else if (w_status) begin
         compare_pin_drive_reg <= hwdata[`VCC_BIT_PINDRV];
      end
   end

   // Bit zero of the control word is the flag itself, so only the enables are stored.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_ctl_reg <= `VCC_CTL_RST;
      end else if (w_irqctl) begin
         irq_ctl_reg <= wr_irqctl;
      end
   end

   // The mask has the layout of the sticky status word.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         imask_reg <= `VCC_CTL_RST;
      end else if (w_imask) begin
         imask_reg <= wr_mask;
      end
   end

   // The change flag is sticky; only a software write of zero clears it.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         compare_change_flag_reg <= 1'b0;
      end else begin
         compare_change_flag_reg <= flag_next;
      end
   end

   // The held copy moves only on a status read, so a slow handler still sees
   // the change that woke it.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         held_result_reg <= 1'b0;
      end else if (rd_status) begin
         held_result_reg <= result;
      end
   end

   // Sticky status, cleared by a read of its own word.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         istat_reg <= `VCC_ISTAT_RST;
      end else begin
         istat_reg <= istat_next;
      end
   end

   // A write is remembered over the address phase and applied when its data
   // arrive; the address is kept every cycle since only the pending bit counts.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= `VCC_ADDR_RST;
      end else begin
         wr_pend_reg <= wr_take;
         wr_addr_reg <= haddr;
      end
   end

   // Read data leave a flop in the data phase and stand until the next read.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hrdata_reg <= `VCC_RST_WORD;
      end else if (rd_take) begin
         hrdata_reg <= rd_mux;
      end
   end

   // The analog switches are registered so they never glitch while the
   // decode settles after a control write.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         analog_reg <= '0;
      end else begin
         analog_reg <= analog_next;
      end
   end

   // Pin B3 trails the synchronised result by one cycle; it is not truly real time.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_out_reg <= 1'b0;
         pin_oe_reg  <= 1'b0;
      end else begin
         pin_out_reg <= pin_next;
         pin_oe_reg  <= compare_pin_drive_reg | pwm_channel_one;
      end
   end

   // Both interrupt outputs are levels; the handler decides which one it uses.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmp_irq_reg <= 1'b0;
         irq_reg     <= 1'b0;
      end else begin
         cmp_irq_reg <= irq_req;
         irq_reg     <= |(istat_next & imask_reg);
      end
   end

   // No wait states and no errors, but both answers still leave a flop.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hreadyout_reg <= `VCC_READY;
         hresp_reg     <= `VCC_RESP_OKAY;
      end else begin
         hreadyout_reg <= `VCC_READY;
         hresp_reg     <= `VCC_RESP_OKAY;
      end
   end

   assign hrdata     = hrdata_reg;
   assign hreadyout  = hreadyout_reg;
   assign hresp      = hresp_reg;
   assign analog_ctl = analog_reg;
   assign pin_b3_out = pin_out_reg;
   assign pin_b3_oe  = pin_oe_reg;
   assign cmp_irq    = cmp_irq_reg;
   assign irq        = irq_reg;
endmodule // vcc_top

// ---- tb/vcc_monitor.sv ----
// Port checker for the voltage comparator control block.
module vcc_monitor
   import vcc_pkg::*;
(
   // Clock and reset.
   input wire logic        clock,
   input wire logic        rst,
   // Watched ports.
   input wire logic        halt_state,
   input wire logic        pwm_channel_one,
   input wire vcc_analog_t analog_ctl,
   input wire logic        pin_b3_out,
   input wire logic        pin_b3_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // The pin path is registered, so it trails the PWM level by one edge.
   sequence s_pwm_differs;
      !$past(rst) && pin_b3_out != $past(pwm_channel_one);
   endsequence
   property p_halt; halt_state |=> !analog_ctl.comp_on; endproperty
   a_halt: assert property (p_halt) else $error("comparator on in halt");
   property p_lvl; analog_ctl.ref_to_inv |-> analog_ctl.ref_level != 4'h0; endproperty
   a_lvl: assert property (p_lvl) else $error("reference with level zero");
   property p_ref; analog_ctl.ref_to_inv |-> analog_ctl.inv_pad == 4'h0; endproperty
   a_ref: assert property (p_ref) else $error("pad and reference both on");
   property p_p2v; analog_ctl.ref_to_inv |-> $onehot0(analog_ctl.noninv_pad); endproperty
   a_p2v: assert property (p_p2v) else $error("several pads selected");
   property p_p2p;
      !analog_ctl.ref_to_inv && analog_ctl.noninv_pad != 4'h0 |-> analog_ctl.inv_pad ==
         {analog_ctl.noninv_pad[2], analog_ctl.noninv_pad[3],
          analog_ctl.noninv_pad[0], analog_ctl.noninv_pad[1]};
   endproperty
   a_p2p: assert property (p_p2p) else $error("pad pair wrong");
   property p_inv1h; $onehot0(analog_ctl.inv_pad); endproperty
   a_inv1h: assert property (p_inv1h) else $error("inverting pads clash");
   property p_oe; pwm_channel_one |=> pin_b3_oe; endproperty
   a_oe: assert property (p_oe) else $error("pin not enabled for pwm");
   property p_out; s_pwm_differs |-> pin_b3_oe; endproperty
   a_out: assert property (p_out) else $error("pin not from pwm");
endmodule // vcc_monitor

bind vcc_top vcc_monitor u_mon (.clock, .rst, .halt_state, .pwm_channel_one, .analog_ctl,
   .pin_b3_out, .pin_b3_oe);

// ---- tb/vcc_top_tb.sv ----
// Self-checking testbench for the voltage comparator control block.
module vcc_top_tb
   import vcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, rst, hsel, hwrite, halt_state, comp_raw, pwm_channel_one, rd_ph;
   logic        hreadyout, hresp, pin_b3_out, pin_b3_oe, cmp_irq, irq;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, r;
   logic [3:0]  vs, ps, np, ip;
   vcc_analog_t analog_ctl;
   logic [31:0] q[$];
   int          errors, checks, i, seed;
   vcc_top uut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .halt_state, .comp_raw,
      .pwm_channel_one, .analog_ctl, .pin_b3_out, .pin_b3_oe, .cmp_irq, .irq);
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task test_done;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Zero wait states are promised, but the master still waits on hready.
   task hwait;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         errors++;
         test_done();
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hwait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_ph <= !w;
      hwait();
      rd_ph <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task wait3;
      repeat (3) @(posedge clock);
   endtask
   always @(posedge clock) begin
      if (rd_ph && hreadyout) begin
         chk("hrdata", hrdata, q.pop_front());
         chk("hresp", {31'h0, hresp}, 32'h0);
      end
   end
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      {rst, hsel, hwrite, halt_state, comp_raw, pwm_channel_one, rd_ph} = 7'h40;
      {haddr, htrans, hwdata} = '0;
      seed = 32'h6542;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk("analog", {18'h0, analog_ctl}, 32'h0);
      rd(12'h000, 32'h0);
      rd(12'h0f0, 32'h0);
      bus(1'b1, 12'h000, 32'h80);
      for (i = 0; i < 32; i++) begin
         r = $random(seed);
         ps = i[3:0];
         vs = (i >= 16) ? 4'h0 : (r[3:0] == 4'h0) ? 4'h1 : r[3:0];
         np = (ps < 4'h4) ? 4'h1 << ps : 4'h0;
         ip = (vs == 4'h0 && ps < 4'h4) ? 4'h1 << (ps ^ 4'h1) : 4'h0;
         bus(1'b1, 12'h004, {24'h0, ps, vs});
         wait3();
         chk("analog", {18'h0, analog_ctl}, {18'h0, 1'b1, vs != 4'h0, vs, np, ip});
      end
      rd(12'h004, {24'h0, ps, vs});
      halt_state <= 1'b1;
      wait3();
      chk("comp_on", {31'h0, analog_ctl.comp_on}, 32'h0);
      halt_state <= 1'b0;
      bus(1'b1, 12'h00c, 32'h6);
      rd(12'h008, 32'h0);
      bus(1'b1, 12'h00c, 32'h6);
      bus(1'b1, 12'h014, 32'h1);
      comp_raw <= 1'b1;
      repeat (6) @(posedge clock);
      chk("cmp_irq", {31'h0, cmp_irq}, 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      rd(12'h010, 32'h3);
      rd(12'h008, 32'h80);
      rd(12'h010, 32'h3);
      wait3();
      chk("irq", {31'h0, irq}, 32'h0);
      chk("cmp_irq", {31'h0, cmp_irq}, 32'h1);
      bus(1'b1, 12'h00c, 32'h6);
      wait3();
      chk("cmp_irq", {31'h0, cmp_irq}, 32'h0);
      bus(1'b1, 12'h00c, 32'h2);
      bus(1'b1, 12'h014, 32'h0);
      comp_raw <= 1'b0;
      repeat (6) @(posedge clock);
      chk("cmp_irq", {31'h0, cmp_irq}, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      rd(12'h00c, 32'h3);
      bus(1'b1, 12'h008, 32'h40);
      pwm_channel_one <= 1'b1;
      wait3();
      chk("pin", {30'h0, pin_b3_oe, pin_b3_out}, 32'h2);
      comp_raw <= 1'b1;
      repeat (6) @(posedge clock);
      chk("pin", {30'h0, pin_b3_oe, pin_b3_out}, 32'h3);
      rd(12'h008, 32'hc0);
      bus(1'b1, 12'h008, 32'h0);
      pwm_channel_one <= 1'b0;
      wait3();
      chk("pin", {30'h0, pin_b3_oe, pin_b3_out}, 32'h0);
      bus(1'b1, 12'h000, 32'h0);
      wait3();
      chk("comp_on", {31'h0, analog_ctl.comp_on}, 32'h0);
      test_done();
   end
endmodule // vcc_top_tb
